// >>> cdp_core.sv
/*
 * Execution datapath: ALU, status flags, 32-entry register file with
 * pointer addressing, 10-bit stack pointer and an Avalon-MM slave.
 * Assumes the decoder issues one request per clock and that the data
 * memory is outside; core clock comes straight from the clock source.
 */
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module cdp_core (
    input  wire logic                  clk,          // Undivided core clock
    input  wire logic                  rst_n,
    input  wire cdp_pkg::cdp_alu_req_s alu_req,
    input  wire cdp_pkg::cdp_ptr_req_s ptr_req,
    input  wire cdp_pkg::cdp_ie_ev_s   ie_ev,
    input  wire cdp_pkg::cdp_sp_op_e   sp_op,
    input  wire logic                  dsp_we,       // Data-space write strobe
    input  wire logic [15:0]           dsp_addr,
    input  wire logic [7:0]            dsp_wdata,
    input  wire logic                  wr16_en,      // 16-bit pair write
    input  wire logic [4:0]            wr16_reg,
    input  wire logic [15:0]           wr16_data,
    input  wire logic [4:0]            rd16_reg,
    input  wire logic                  irq_pending,
    output logic [15:0]                rd16_data,
    output logic                       irq_accept,
    output logic [7:0]                 alu_result,
    output logic [15:0]                ptr_addr,
    output logic                       dsp_hit_regfile,
    output logic                       dsp_hit_io,
    output logic [7:0]                 dsp_rdata,
    output logic [9:0]                 stack_addr,
    output logic [7:0]                 status_flags,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest
);
    logic [7:0]  regs_q [32];
    logic [7:0]  status_q;
    logic [9:0]  sp_q;
    logic [31:0] rdata_q;
    logic        ack_q;

    // Clock and reset shared by the checks that leave them out
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Operand fetch and ALU
    wire  cdp_pkg::cdp_op_e op = alu_req.op;
    wire  [7:0] a      = regs_q[alu_req.rd];
    wire  [7:0] b      = alu_req.use_imm ? alu_req.imm : regs_q[alu_req.rr];
    wire        cin    = status_q[cdp_pkg::FLAG_C];
    wire        is_add = (op == cdp_pkg::CDP_OP_ADD) || (op == cdp_pkg::CDP_OP_ADC);
    wire        is_sub = (op == cdp_pkg::CDP_OP_SUB) || (op == cdp_pkg::CDP_OP_SBC);
    wire        cy     = ((op == cdp_pkg::CDP_OP_ADC) || (op == cdp_pkg::CDP_OP_SBC)) & cin;
    wire  [8:0] sum    = {1'b0, a} + {1'b0, b} + {8'h00, cy};
    wire  [8:0] dif    = {1'b0, a} - {1'b0, b} - {8'h00, cy};
    wire  [4:0] hsum   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
    wire  [4:0] hdif   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
    wire  [4:0] wreg   = {alu_req.rd[4:1], 1'b0};
    wire [15:0] wsrc   = {regs_q[wreg + 5'h01], regs_q[wreg]};
    wire [15:0] wsum   = wsrc + {10'h000, alu_req.imm[5:0]};
    logic [7:0] res;
    logic       writes, fh, fv, fc, upd_hv, upd_c, upd_nz;

    // Result and flag-effect selection per operation
    always_comb begin
        res = a;
        writes = 1'b1;
        fh = 1'b0;
        fv = 1'b0;
        fc = cin;
        upd_hv = 1'b0;
        upd_c = 1'b0;
        upd_nz = 1'b1;
        unique case (op)
            cdp_pkg::CDP_OP_ADD, cdp_pkg::CDP_OP_ADC: begin
                res = sum[7:0];
                fh = hsum[4];
                fv = (a[7] == b[7]) && (sum[7] != a[7]);
                fc = sum[8];
                upd_hv = 1'b1;
                upd_c = 1'b1;
            end
            cdp_pkg::CDP_OP_SUB, cdp_pkg::CDP_OP_SBC: begin
                res = dif[7:0];
                fh = hdif[4];
                fv = (a[7] != b[7]) && (dif[7] != a[7]);
                fc = dif[8];
                upd_hv = 1'b1;
                upd_c = 1'b1;
            end
            cdp_pkg::CDP_OP_AND: res = a & b;
            cdp_pkg::CDP_OP_OR:  res = a | b;
            cdp_pkg::CDP_OP_XOR: res = a ^ b;
            cdp_pkg::CDP_OP_MOV: begin
                res = b;
                upd_nz = 1'b0;
            end
            cdp_pkg::CDP_OP_COM: begin
                res = ~a;
                fc = 1'b1;
                upd_c = 1'b1;
            end
            cdp_pkg::CDP_OP_LSR: begin
                res = {1'b0, a[7:1]};
                fc = a[0];
                fv = a[0];
                upd_c = 1'b1;
            end
            cdp_pkg::CDP_OP_BLD: begin
                res = a;
                res[alu_req.bitsel] = status_q[cdp_pkg::FLAG_T];
                upd_nz = 1'b0;
            end
            cdp_pkg::CDP_OP_BST: begin
                writes = 1'b0;
                upd_nz = 1'b0;
            end
            default: begin                                              // NONE and ADIW
                writes = 1'b0;
                upd_nz = 1'b0;
            end
        endcase
    end

    wire        alu_go = alu_req.valid && (op != cdp_pkg::CDP_OP_NONE);
    wire        is_logic = (op == cdp_pkg::CDP_OP_AND) || (op == cdp_pkg::CDP_OP_OR) ||
                           (op == cdp_pkg::CDP_OP_XOR) || (op == cdp_pkg::CDP_OP_COM);
    wire        is_adiw = op == cdp_pkg::CDP_OP_ADIW;
    wire        nn = is_adiw ? wsum[15] : res[7];
    wire        zz = is_adiw ? (wsum == 16'h0000) : (res == 8'h00);
    wire        vv = is_adiw ? (~wsrc[15] & wsum[15]) : (is_logic ? 1'b0 : fv);
    wire        cc = is_adiw ? (wsrc[15] & ~wsum[15]) : fc;

    // Status next value: arithmetic flags then interrupt enable events
    logic [7:0] st_d;
    always_comb begin
        st_d = status_q;
        if (alu_go && (upd_nz || is_adiw)) begin
            st_d[cdp_pkg::FLAG_N] = nn;
            st_d[cdp_pkg::FLAG_Z] = zz;
            st_d[cdp_pkg::FLAG_V] = (upd_hv || is_logic || is_adiw ||
                                     op == cdp_pkg::CDP_OP_LSR) ? vv : status_q[cdp_pkg::FLAG_V];
            st_d[cdp_pkg::FLAG_S] = nn ^ st_d[cdp_pkg::FLAG_V];
        end
        if (alu_go && (upd_c || is_adiw))
            st_d[cdp_pkg::FLAG_C] = cc;
        if (alu_go && upd_hv)
            st_d[cdp_pkg::FLAG_H] = fh;
        if (alu_go && op == cdp_pkg::CDP_OP_BST)
            st_d[cdp_pkg::FLAG_T] = a[alu_req.bitsel];
        if (ie_ev.irq_return || ie_ev.set_ie)
            st_d[cdp_pkg::FLAG_I] = 1'b1;
        if (ie_ev.irq_taken || ie_ev.clr_ie)
            st_d[cdp_pkg::FLAG_I] = 1'b0;
    end
    // No save or restore of status on interrupt entry/return

    // Interrupt gate; immediate clear also blocks same cycle
    assign irq_accept = irq_pending && status_q[cdp_pkg::FLAG_I] && !ie_ev.clr_ie;

    // Pointer addressing
    wire  [4:0] plo = (ptr_req.sel == 2'd0) ? cdp_pkg::PTR_X_LO :
                      (ptr_req.sel == 2'd1) ? cdp_pkg::PTR_Y_LO : cdp_pkg::PTR_Z_LO;
    wire [15:0] pval = {regs_q[plo + 5'h01], regs_q[plo]};
    wire [15:0] pdec = pval - 16'h0001;
    wire [15:0] pinc = pval + 16'h0001;
    wire [15:0] pea  = (ptr_req.mode == cdp_pkg::CDP_PM_PREDEC) ? pdec :
                       (ptr_req.mode == cdp_pkg::CDP_PM_DISP) ? pval + {10'h000, ptr_req.disp} :
                       pval;
    wire        pupd = ptr_req.valid && (ptr_req.mode != cdp_pkg::CDP_PM_DISP);
    wire [15:0] pnew = (ptr_req.mode == cdp_pkg::CDP_PM_PREDEC) ? pdec : pinc;

    // Data-space decode
    wire        hit_rf = dsp_addr <= cdp_pkg::REGFILE_LAST;
    wire        hit_io = (dsp_addr >= cdp_pkg::IO_FIRST) && (dsp_addr <= cdp_pkg::IO_LAST);
    assign dsp_hit_regfile = hit_rf;
    assign dsp_hit_io      = hit_io;
    assign dsp_rdata       = hit_rf ? regs_q[dsp_addr[4:0]] : 8'h00;
    assign ptr_addr        = pea;
    assign rd16_data       = {regs_q[{rd16_reg[4:1], 1'b1}], regs_q[{rd16_reg[4:1], 1'b0}]};
    assign alu_result      = res;
    assign status_flags    = status_q;

    // Register file: one write port per form, earlier ones win
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_reg
            localparam logic [4:0] IDX = 5'(gi);
            wire alu_w  = alu_go && writes && (alu_req.rd == IDX);
            wire adw_lo = alu_go && is_adiw && (wreg == IDX);
            wire adw_hi = alu_go && is_adiw && (wreg + 5'h01 == IDX);
            wire w16_lo = wr16_en && ({wr16_reg[4:1], 1'b0} == IDX);
            wire w16_hi = wr16_en && ({wr16_reg[4:1], 1'b1} == IDX);
            wire p_lo   = pupd && (plo == IDX);
            wire p_hi   = pupd && (plo + 5'h01 == IDX);
            wire ds_w   = dsp_we && hit_rf && (dsp_addr[4:0] == IDX);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    regs_q[gi] <= 8'h00;
                else if (ds_w)
                    regs_q[gi] <= dsp_wdata;
                else if (p_lo)
                    regs_q[gi] <= pnew[7:0];
                else if (p_hi)
                    regs_q[gi] <= pnew[15:8];
                else if (w16_lo)
                    regs_q[gi] <= wr16_data[7:0];
                else if (w16_hi)
                    regs_q[gi] <= wr16_data[15:8];
                else if (adw_lo)
                    regs_q[gi] <= wsum[7:0];
                else if (adw_hi)
                    regs_q[gi] <= wsum[15:8];
                else if (alu_w)
                    regs_q[gi] <= res;
            end
        end
    endgenerate

    // Stack pointer movement
    logic [9:0] sp_d;
    always_comb begin
        sp_d = sp_q;
        unique case (sp_op)
            cdp_pkg::CDP_SP_PUSH1: sp_d = sp_q - 10'd1;
            cdp_pkg::CDP_SP_POP1:  sp_d = sp_q + 10'd1;
            cdp_pkg::CDP_SP_PUSH2: sp_d = sp_q - 10'd2;
            cdp_pkg::CDP_SP_POP2:  sp_d = sp_q + 10'd2;
            default:               sp_d = sp_q;
        endcase
    end
    // Push writes at current SP, single-byte pop reads at SP+1, two-byte pop at SP
    assign stack_addr = (sp_op == cdp_pkg::CDP_SP_POP1) ? sp_q + 10'd1 : sp_q;

    // Avalon slave: one wait cycle, answer on the following edge
    wire        req   = (avs_read || avs_write) && !ack_q;
    wire        wr_go = avs_write && ack_q;
    wire        w_st  = wr_go && (avs_address == cdp_pkg::REG_STATUS_OFS) && avs_byteenable[0];
    wire        w_spl = wr_go && (avs_address == cdp_pkg::REG_SP_LOW_OFS) && avs_byteenable[0];
    wire        w_sph = wr_go && (avs_address == cdp_pkg::REG_SP_HIGH_OFS) && avs_byteenable[0];
    wire  [7:0] wr_st = {avs_writedata[7:5], avs_writedata[2] ^ avs_writedata[3], avs_writedata[3:0]};
    wire [31:0] rsel  = (avs_address == cdp_pkg::REG_STATUS_OFS)  ? {24'h0, status_q} :
                        (avs_address == cdp_pkg::REG_SP_LOW_OFS)  ? {24'h0, sp_q[7:0]} :
                        (avs_address == cdp_pkg::REG_SP_HIGH_OFS) ?
                            {24'h0, {6'h00, sp_q[9:8]} & cdp_pkg::SPH_MASK} : 32'h0;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;

    // Flag and stack state; bus writes land on the completing edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= cdp_pkg::STATUS_RESET;
            sp_q     <= cdp_pkg::SP_RESET;
        end else begin
            status_q <= w_st ? wr_st : st_d;
            if (w_spl)
                sp_q <= {sp_d[9:8], avs_writedata[7:0]};
            else if (w_sph)
                sp_q <= {avs_writedata[1:0], sp_d[7:0]};
            else
                sp_q <= sp_d;
        end
    end

    // Bus handshake state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= req;
            rdata_q <= (req && avs_read) ? rsel : rdata_q;
        end
    end
    // One undivided clock, one operation per edge

    // Checks
    property p_sign;
        @(posedge clk) disable iff (!rst_n)
        status_q[cdp_pkg::FLAG_S] == (status_q[cdp_pkg::FLAG_N] ^ status_q[cdp_pkg::FLAG_V]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag mismatch");
    property p_gate;
        @(posedge clk) disable iff (!rst_n) !status_q[cdp_pkg::FLAG_I] |-> !irq_accept;
    endproperty
    a_gate: assert property (p_gate) else $error("irq taken while disabled");
    property p_irq_clr;
        @(posedge clk) disable iff (!rst_n) ie_ev.irq_taken && !w_st |=> !status_q[cdp_pkg::FLAG_I];
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("ie not cleared");
    property p_irq_return_insn;
        @(posedge clk) disable iff (!rst_n)
        ie_ev.irq_return && !ie_ev.irq_taken && !ie_ev.clr_ie && !w_st |=> status_q[cdp_pkg::FLAG_I];
    endproperty
    a_irq_return_insn: assert property (p_irq_return_insn) else $error("ie not set");
    property p_push1;
        @(posedge clk) disable iff (!rst_n)
        sp_op == cdp_pkg::CDP_SP_PUSH1 && !w_spl && !w_sph |=> sp_q == $past(sp_q) - 10'd1;
    endproperty
    a_push1: assert property (p_push1) else $error("push1 step wrong");
    property p_pop2;
        @(posedge clk) disable iff (!rst_n)
        sp_op == cdp_pkg::CDP_SP_POP2 && !w_spl && !w_sph |=> sp_q == $past(sp_q) + 10'd2;
    endproperty
    a_pop2: assert property (p_pop2) else $error("pop2 step wrong");
    property p_add_wb;
        @(posedge clk) disable iff (!rst_n)
        alu_go && op == cdp_pkg::CDP_OP_ADD && !dsp_we && !pupd && !wr16_en
        |=> regs_q[$past(alu_req.rd)] == $past(sum[7:0]);
    endproperty
    a_add_wb: assert property (p_add_wb) else $error("add result not written");
    property p_zero;
        @(posedge clk) disable iff (!rst_n)
        alu_go && is_add && !w_st |=> status_q[cdp_pkg::FLAG_Z] == ($past(sum[7:0]) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    // Flag checks rebuilt from operand and result bits plus the set_ie enable check, then stack and pointer steps
    property p_half;
        alu_go && is_add && !w_st
        |=> status_q[cdp_pkg::FLAG_H] == $past((a[3] & b[3]) | (b[3] & ~sum[3]) | (~sum[3] & a[3]));
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");
    property p_add_v;
        alu_go && is_add && !w_st
        |=> status_q[cdp_pkg::FLAG_V] == $past((a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]));
    endproperty
    a_add_v: assert property (p_add_v) else $error("overflow flag wrong");
    property p_add_c;
        alu_go && is_add && !w_st
        |=> status_q[cdp_pkg::FLAG_C] == $past((a[7] & b[7]) | (b[7] & ~sum[7]) | (~sum[7] & a[7]));
    endproperty
    a_add_c: assert property (p_add_c) else $error("add carry wrong");
    property p_sub_c;
        alu_go && is_sub && !w_st
        |=> status_q[cdp_pkg::FLAG_C] == $past((~a[7] & b[7]) | (b[7] & dif[7]) | (dif[7] & ~a[7]));
    endproperty
    a_sub_c: assert property (p_sub_c) else $error("borrow flag wrong");
    property p_neg;
        alu_go && is_add && !w_st
        |=> status_q[cdp_pkg::FLAG_N] == $past(sum[7]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    property p_bst;
        alu_go && op == cdp_pkg::CDP_OP_BST && !w_st
        |=> status_q[cdp_pkg::FLAG_T] == $past(regs_q[alu_req.rd][alu_req.bitsel]);
    endproperty
    a_bst: assert property (p_bst) else $error("bit copy flag wrong");
    property p_sei;
        ie_ev.set_ie && !ie_ev.irq_taken && !ie_ev.clr_ie && !w_st
        |=> status_q[cdp_pkg::FLAG_I];
    endproperty
    a_sei: assert property (p_sei) else $error("ie not set by insn");
    property p_push2;
        sp_op == cdp_pkg::CDP_SP_PUSH2 && !w_spl && !w_sph
        |=> sp_q == $past(sp_q) - 10'd2;
    endproperty
    a_push2: assert property (p_push2) else $error("push2 step wrong");
    property p_pop1;
        sp_op == cdp_pkg::CDP_SP_POP1 && !w_spl && !w_sph
        |=> sp_q == $past(sp_q) + 10'd1;
    endproperty
    a_pop1: assert property (p_pop1) else $error("pop1 step wrong");
    property p_ptr_inc;
        ptr_req.valid && ptr_req.mode == cdp_pkg::CDP_PM_POSTINC && !dsp_we
        |=> {regs_q[$past(plo) + 5'h01], regs_q[$past(plo)]} == $past(pval) + 16'h0001;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");
    sequence s_bus_req;
        (avs_read || avs_write) && !ack_q;
    endsequence
    property p_bus;
        @(posedge clk) disable iff (!rst_n) s_bus_req |=> !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule // cdp_core

// >>> cdp_mem_model.sv
/*
 * Data memory model that faces the stack side of the datapath.
 * Assumes the datapath gives the stack address and stack operation each cycle.
 */
`timescale 1ns/10ps
module cdp_mem_model (
    input  wire logic               clk,
    input  wire cdp_pkg::cdp_sp_op_e sp_op,
    input  wire logic [9:0]         stack_addr,
    input  wire logic [7:0]         wdata,
    output logic [7:0]              rdata
);
    logic [7:0] mem [0:1023];
    logic [7:0] noise_q;
    wire        pop_w = (sp_op == cdp_pkg::CDP_SP_POP1);
    // Byte push lands at the current top before the pointer moves down
    always @(posedge clk) begin
        noise_q <= ~noise_q + 8'h3b;
        if (sp_op == cdp_pkg::CDP_SP_PUSH1) mem[stack_addr] <= wdata;
    end
    // Read data is only valid during a single-byte pop; otherwise it churns
    assign rdata = pop_w ? mem[stack_addr] : noise_q;
    initial noise_q = 8'h00;
endmodule // cdp_mem_model

// >>> cdp_pkg.sv
/*
 * Package for the execution datapath: register map, flag positions,
 * operation codes and the structs that carry decoder requests.
 * Assumes one core clock and an Avalon-MM master for register access.
 */
package cdp_pkg;
    // Avalon register byte offsets
    localparam logic [3:0] REG_STATUS_OFS  = 4'h0;
    localparam logic [3:0] REG_SP_LOW_OFS  = 4'h4;
    localparam logic [3:0] REG_SP_HIGH_OFS = 4'h8;
    // Status flag bit positions
    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    // Reset values and the SP high-byte read mask
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [9:0] SP_RESET     = 10'h000;
    localparam logic [7:0] SPH_MASK     = 8'h03;
    // Data space windows
    localparam logic [15:0] REGFILE_LAST = 16'h001f;
    localparam logic [15:0] IO_FIRST     = 16'h0020;
    localparam logic [15:0] IO_LAST      = 16'h005f;
    // Pointer base register indices
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;

    typedef enum logic [3:0] {
        CDP_OP_NONE, CDP_OP_ADD, CDP_OP_ADC, CDP_OP_SUB, CDP_OP_SBC,
        CDP_OP_AND, CDP_OP_OR, CDP_OP_XOR, CDP_OP_MOV, CDP_OP_COM,
        CDP_OP_LSR, CDP_OP_BST, CDP_OP_BLD, CDP_OP_ADIW
    } cdp_op_e;

    typedef enum logic [1:0] {
        CDP_PM_DISP, CDP_PM_POSTINC, CDP_PM_PREDEC
    } cdp_ptr_mode_e;

    typedef enum logic [2:0] {
        CDP_SP_HOLD, CDP_SP_PUSH1, CDP_SP_POP1, CDP_SP_PUSH2, CDP_SP_POP2
    } cdp_sp_op_e;

    // One decoded instruction from the decoder
    typedef struct packed {
        logic       valid;
        cdp_op_e    op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic       use_imm;
        logic [7:0] imm;
        logic [2:0] bitsel;
    } cdp_alu_req_s;

    // Pointer-indirect access request
    typedef struct packed {
        logic          valid;
        logic [1:0]    sel;
        cdp_ptr_mode_e mode;
        logic [5:0]    disp;
    } cdp_ptr_req_s;

    // Global interrupt enable events
    typedef struct packed {
        logic irq_taken;
        logic irq_return;
        logic set_ie;
        logic clr_ie;
    } cdp_ie_ev_s;
endpackage

// >>> testbench.sv
/*
 * Self-checking bench for the execution datapath: Avalon register access,
 * ALU and flags, interrupt enable, pointers, stack and data-space decode.
 * Assumes the datapath and its package are compiled first.
 */
`timescale 1ns/10ps
module testbench;
    logic clk = 0, rst_n = 0, dsp_we = 0, wr16_en = 0, irq_pending = 0;
    logic avs_read = 0, avs_write = 0;
    cdp_pkg::cdp_alu_req_s alu_req = '0;
    cdp_pkg::cdp_ptr_req_s ptr_req = '0;
    cdp_pkg::cdp_ie_ev_s   ie_ev   = '0;
    cdp_pkg::cdp_sp_op_e   sp_op   = cdp_pkg::CDP_SP_HOLD;
    logic [15:0] dsp_addr = '0, wr16_data = '0, rd16_data, ptr_addr;
    logic [7:0]  dsp_wdata = '0, alu_result, dsp_rdata, status_flags, mem_wdata = '0, mem_rdata;
    logic [4:0]  wr16_reg = '0, rd16_reg = '0;
    logic [3:0]  avs_address = '0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [9:0]  stack_addr;
    logic        irq_accept, dsp_hit_regfile, dsp_hit_io, avs_waitrequest;
    int fail_count = 0, cmp_count = 0;
    localparam logic [7:0] A_V [3] = '{8'h0f, 8'h7f, 8'hff};
    localparam logic [7:0] F_V [3] = '{8'h20, 8'h2c, 8'h23};
    localparam logic [7:0] R_V [3] = '{8'h10, 8'h80, 8'h00};
    localparam cdp_pkg::cdp_op_e O_V [10] = '{cdp_pkg::CDP_OP_ADC, cdp_pkg::CDP_OP_SUB, cdp_pkg::CDP_OP_SBC,
        cdp_pkg::CDP_OP_AND, cdp_pkg::CDP_OP_OR, cdp_pkg::CDP_OP_XOR, cdp_pkg::CDP_OP_MOV, cdp_pkg::CDP_OP_COM,
        cdp_pkg::CDP_OP_LSR, cdp_pkg::CDP_OP_ADIW};
    localparam logic [7:0] OA_V [10] = '{8'h38, 8'h10, 8'h80, 8'hf0, 8'h80, 8'haa, 8'h33, 8'h0f, 8'h01, 8'hff};
    localparam logic [7:0] OI_V [10] = '{8'h07, 8'h20, 8'h00, 8'h0f, 8'h01, 8'haa, 8'h5a, 8'h00, 8'h00, 8'h01};
    localparam logic [7:0] OR_V [10] = '{8'h40, 8'hf0, 8'h7f, 8'h00, 8'h81, 8'h00, 8'h5a, 8'hf0, 8'h00, 8'h00};
    localparam logic [7:0] OF_V [10] = '{8'h60, 8'h55, 8'h78, 8'h62, 8'h74, 8'h62, 8'h62, 8'h75, 8'h7b, 8'h60};

    cdp_core dut (.*);
    cdp_mem_model mem (.clk(clk), .sp_op(sp_op), .stack_addr(stack_addr), .wdata(mem_wdata), .rdata(mem_rdata));

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Avalon access: hold request until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a; avs_writedata <= d; avs_read <= !wr; avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0; avs_write <= 1'b0;
    endtask
    task automatic dw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk); dsp_we <= 1'b1; dsp_addr <= a; dsp_wdata <= d;
        @(posedge clk); dsp_we <= 1'b0;
    endtask
    task automatic alu(input cdp_pkg::cdp_op_e op, input logic [4:0] rd, input logic [7:0] imm, input logic [2:0] b);
        @(posedge clk); alu_req <= '{1'b1, op, rd, 5'h00, 1'b1, imm, b};
        @(posedge clk); alu_req.valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic ie(input cdp_pkg::cdp_ie_ev_s ev, input logic [7:0] exp);
        @(posedge clk); ie_ev <= ev;
        @(posedge clk); ie_ev <= '0;
        @(negedge clk);
        chk(status_flags, exp);
        chk(irq_accept, exp[7]);
    endtask
    task automatic ptr(input cdp_pkg::cdp_ptr_mode_e m, input logic [5:0] d, input logic [15:0] ea, input logic [15:0] x);
        @(posedge clk); ptr_req <= '{1'b1, 2'd0, m, d};
        @(negedge clk); chk(ptr_addr, ea);
        @(posedge clk); ptr_req.valid <= 1'b0;
        @(negedge clk); chk(rd16_data, x);
    endtask
    task automatic sp_step(input cdp_pkg::cdp_sp_op_e op, input logic [9:0] a);
        @(posedge clk); sp_op <= op;
        @(negedge clk); chk(stack_addr, a);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog cuts a hung run short
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end

    // Main test sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk(status_flags, 8'h00);
        for (int i = 0; i < 4; i++) begin
            av(1'b0, 4'(i * 4), '0); chk(q, '0);
        end
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            dw(16'h0001, A_V[i]);
            alu(cdp_pkg::CDP_OP_ADD, 5'd1, 8'h01, 3'd0);
            chk(status_flags, F_V[i]);
            @(posedge clk); rd16_reg <= 5'd0; @(negedge clk); chk(rd16_data[15:8], R_V[i]);
            chk(alu_result, R_V[i] + 8'h01);
        end
        $display("alu flags done");
        dw(16'h0003, 8'h04);
        alu(cdp_pkg::CDP_OP_BST, 5'd3, 8'h00, 3'd2); chk(status_flags, 8'h63);
        alu(cdp_pkg::CDP_OP_BLD, 5'd4, 8'h00, 3'd7);
        @(posedge clk); dsp_addr <= 16'h0004; @(negedge clk); chk(dsp_rdata, 8'h80);
        $display("bit copy done");
        @(posedge clk); irq_pending <= 1'b1; @(negedge clk); chk(irq_accept, 1'b0);
        ie('{1'b0, 1'b0, 1'b1, 1'b0}, 8'he3);
        ie('{1'b1, 1'b0, 1'b0, 1'b0}, 8'h63);
        ie('{1'b0, 1'b1, 1'b0, 1'b0}, 8'he3);
        ie('{1'b0, 1'b0, 1'b0, 1'b1}, 8'h63);
        $display("interrupt enable done");
        @(posedge clk); wr16_en <= 1'b1; wr16_reg <= 5'd26; wr16_data <= 16'h0120;
        @(posedge clk); wr16_en <= 1'b0; rd16_reg <= 5'd26; dsp_addr <= 16'h001a;
        @(negedge clk); chk(rd16_data, 16'h0120); chk(dsp_rdata, 8'h20);
        ptr(cdp_pkg::CDP_PM_DISP, 6'd63, 16'h015f, 16'h0120);
        ptr(cdp_pkg::CDP_PM_POSTINC, 6'd0, 16'h0120, 16'h0121);
        ptr(cdp_pkg::CDP_PM_PREDEC, 6'd0, 16'h0120, 16'h0120);
        $display("pointers done");
        av(1'b1, 4'h4, 32'h0000_0000); av(1'b1, 4'h8, 32'h0000_00ff);
        av(1'b0, 4'h8, '0); chk(q, 32'h3);
        av(1'b1, 4'hc, 32'h0000_00ff); av(1'b0, 4'hc, '0); chk(q, '0);
        @(posedge clk); mem_wdata <= 8'ha5;
        sp_step(cdp_pkg::CDP_SP_PUSH1, 10'h300);
        sp_step(cdp_pkg::CDP_SP_PUSH2, 10'h2ff);
        sp_step(cdp_pkg::CDP_SP_POP2, 10'h2fd);
        sp_step(cdp_pkg::CDP_SP_POP1, 10'h300); chk(mem_rdata, 8'ha5);
        sp_step(cdp_pkg::CDP_SP_HOLD, 10'h300);
        $display("stack done");
        @(posedge clk); dsp_addr <= 16'h001f; @(negedge clk); chk({dsp_hit_regfile, dsp_hit_io}, 2'b10);
        @(posedge clk); dsp_addr <= 16'h0020; @(negedge clk); chk({dsp_hit_regfile, dsp_hit_io}, 2'b01);
        @(posedge clk); dsp_addr <= 16'h005f; @(negedge clk); chk({dsp_hit_regfile, dsp_hit_io}, 2'b01);
        @(posedge clk); dsp_addr <= 16'h0060; @(negedge clk); chk({dsp_hit_regfile, dsp_hit_io}, 2'b00);
        $display("decode done");
        // Every remaining operation code except NONE, flags carried from one to the next
        for (int i = 0; i < 10; i++) begin
            dw(16'h0004, OA_V[i]); alu(O_V[i], 5'd4, OI_V[i], 3'd0);
            chk(dsp_rdata, OR_V[i]); chk(status_flags, OF_V[i]);
        end
        $display("operation set done");
        report_and_stop;
    end
endmodule // testbench
